// ===== src/scr_regs.sv
`timescale 1ns/1ns
// Contract
// - Phase-adjust bit 28 set makes each register 0 write step the phase.
// - Hold 24-bit phase value; with bit 28 set, each register 0 write adds it to phase.
// - Code 0100 steers word into reference and charge-pump register.
// - Bits 29..27 select the test output source.
// - Bit 26 doubles the reference, making both edges active.
// - Bit 25 inserts divide-by-two toggle between divider and detector.
// - Ten-bit reference divider ratio 1 to 1023.
// - Bit 14 holds output-divider select until next register 0 write.
// - Bits 13..10 set the charge pump current.
// - Bit 7 sets phase detector polarity, 1 positive.
// - Bit 6 powers down; registers keep contents.
// - Power-down loads counters, resets lock, tristates pump, disables outputs.
// - Bit 5 forces charge pump three-state.
// - Bit 4 holds counters and band select in reset.
// - Code 0110 steers feedback/bleed word; host writes fixed reserved bits.
// - Bit 30 gates bleed until lock; bit 29 enables negative bleed.
// - Bit 24 picks direct oscillator or divided feedback.
// - Bits 23..21 output divider; bits 20..13 bleed current.
// - Register 0 write resets modulator unless disable bit set.
module scr_regs
(
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    // Three-wire serial port, sampled on clk_in
    input  wire logic                       sclk_in,
    input  wire logic                       sdata_in,
    input  wire logic                       load_en_in,
    // Lock status from loop
    input  wire logic                       lock_detect_in,
    // Phase and modulator
    output logic                            phase_step_out,
    output logic [scr_pkg::PH_W-1:0]        phase_acc_out,
    output logic                            modulator_reset_out,
    // Reference path
    output logic [2:0]                      test_output_select_out,
    output logic                            reference_doubler_enable_out,
    output logic                            reference_half_divide_out,
    output logic [9:0]                      ref_divide_ratio_out,
    output logic                            output_logic_level_out,
    // Charge pump
    output logic [3:0]                      charge_pump_current_out,
    output logic                            detector_polarity_out,
    output logic                            charge_pump_tristate_out,
    output logic                            counters_reset_out,
    output logic                            outputs_disable_out,
    output logic                            lock_detect_reset_out,
    // Feedback and bleed
    output logic                            bleed_enable_out,
    output logic [7:0]                      bleed_current_out,
    output logic                            feedback_source_select_out,
    output logic [2:0]                      output_divider_select_out,
    output logic                            fixed_word_ok_out
);
    import scr_pkg::*;

    logic [WORD_W-1:0] shift_reg;
    logic [CNT_W-1:0]  count_reg;
    logic              sclk_d_reg;
    logic              le_d_reg;
    logic [WORD_W-1:0] phase_reg;
    logic [WORD_W-1:0] refcp_reg;
    logic [WORD_W-1:0] fixed_reg;
    logic [WORD_W-1:0] fdbk_reg;
    logic [2:0]        odiv_reg;
    logic              latch_w;
    logic              reg0_w;
    logic [SEL_W-1:0]  sel_w;

    // Decodes the select code of a latched word
    function automatic logic hit(input logic [WORD_W-1:0] w, input logic [SEL_W-1:0] code);
        hit = (w[SEL_W-1:0] == code);
    endfunction

    // Edge detect of serial clock and load enable; inputs are already synchronous
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sclk_d_reg <= 1'b0;
            le_d_reg   <= 1'b0;
        end
        else
        begin
            sclk_d_reg <= sclk_in;
            le_d_reg   <= load_en_in;
        end
    end

    assign latch_w = load_en_in && !le_d_reg;
    assign sel_w   = shift_reg[SEL_W-1:0];
    assign reg0_w  = latch_w && hit(shift_reg, SEL_REG0);

    // Shift in on rising serial clock, MSB first; keeps working in power-down
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            shift_reg <= ZERO_WORD;
            count_reg <= CNT_ZERO;
        end
        else if (latch_w)
        begin
            count_reg <= CNT_ZERO;
        end
        else if (sclk_in && !sclk_d_reg && !load_en_in)
        begin
            shift_reg <= {shift_reg[WORD_W-2:0], sdata_in};
            if (count_reg != CNT_FULL)
                count_reg <= count_reg + 6'h01;
        end
    end

    // Register steering on latch; short frames are still latched as seen
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            phase_reg <= ZERO_WORD;
            refcp_reg <= ZERO_WORD;
            fixed_reg <= ZERO_WORD;
            fdbk_reg  <= ZERO_WORD;
        end
        else if (latch_w)
        begin
            if (sel_w == SEL_PHASE)
                phase_reg <= shift_reg;
            if (sel_w == SEL_REFCP)
                refcp_reg <= shift_reg;
            if (sel_w == SEL_FIXED)
                fixed_reg <= shift_reg;
            if (sel_w == SEL_FDBK)
                fdbk_reg <= shift_reg;
        end
    end

    // Output divider select, optionally held until register 0 commits
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            odiv_reg <= 3'h0;
        else if (latch_w && hit(shift_reg, SEL_FDBK) && !refcp_reg[DBUF_B])
            odiv_reg <= shift_reg[ODIV_HI:ODIV_LO];
        else if (reg0_w)
            odiv_reg <= fdbk_reg[ODIV_HI:ODIV_LO];
    end

    // Phase accumulator steps on every commit when adjust is enabled
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            phase_acc_out       <= 24'h0;
            phase_step_out      <= 1'b0;
            modulator_reset_out <= 1'b0;
        end
        else
        begin
            phase_step_out      <= reg0_w && phase_reg[PHADJ_B];
            modulator_reset_out <= reg0_w && !phase_reg[SDDIS_B];
            if (reg0_w && phase_reg[PHADJ_B])
                phase_acc_out <= phase_acc_out + phase_reg[PH_HI:PH_LO];
        end
    end

    // Control outputs decoded from stored fields; all registered
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            test_output_select_out       <= 3'h0;
            reference_doubler_enable_out <= 1'b0;
            reference_half_divide_out    <= 1'b0;
            ref_divide_ratio_out         <= 10'h001;
            output_logic_level_out       <= 1'b0;
            charge_pump_current_out      <= 4'h0;
            detector_polarity_out        <= 1'b0;
            charge_pump_tristate_out     <= 1'b1;
            counters_reset_out           <= 1'b1;
            outputs_disable_out          <= 1'b1;
            lock_detect_reset_out        <= 1'b1;
            bleed_enable_out             <= 1'b0;
            bleed_current_out            <= 8'h00;
            feedback_source_select_out   <= 1'b0;
            output_divider_select_out    <= 3'h0;
            fixed_word_ok_out            <= 1'b0;
        end
        else
        begin
            test_output_select_out       <= refcp_reg[MUX_HI:MUX_LO];
            reference_doubler_enable_out <= refcp_reg[DBL_B];
            reference_half_divide_out    <= refcp_reg[HALF_B];
            // Ratio 0 is not legal; treat it as divide by one
            ref_divide_ratio_out         <= (refcp_reg[RDIV_HI:RDIV_LO] == 10'h000) ? 10'h001
                                            : refcp_reg[RDIV_HI:RDIV_LO];
            output_logic_level_out       <= refcp_reg[LVL_B];
            charge_pump_current_out      <= refcp_reg[CP_HI:CP_LO];
            detector_polarity_out        <= refcp_reg[POL_B];
            charge_pump_tristate_out     <= refcp_reg[TRI_B] || refcp_reg[PD_B];
            counters_reset_out           <= refcp_reg[CRST_B] || refcp_reg[PD_B];
            outputs_disable_out          <= refcp_reg[PD_B];
            lock_detect_reset_out        <= refcp_reg[PD_B];
            bleed_enable_out             <= fdbk_reg[NBL_B] && (!fdbk_reg[GBL_B] || lock_detect_in);
            bleed_current_out            <= fdbk_reg[BL_HI:BL_LO];
            feedback_source_select_out   <= fdbk_reg[FBS_B];
            output_divider_select_out    <= odiv_reg;
            fixed_word_ok_out            <= (fixed_reg == FIXED_WORD);
        end
    end

    // Checks: control bits reach their outputs one edge after the stored word
    a_power_down_forces: assert property (@(posedge clk_in) disable iff (rst_in)
        refcp_reg[PD_B] |=> (charge_pump_tristate_out && counters_reset_out && outputs_disable_out))
        else $error("power-down effects missing");
    a_tristate_bit: assert property (@(posedge clk_in) disable iff (rst_in)
        refcp_reg[TRI_B] |=> charge_pump_tristate_out)
        else $error("tristate not applied");
    a_counter_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        refcp_reg[CRST_B] |=> counters_reset_out)
        else $error("counter reset not applied");
    a_regs_kept: assert property (@(posedge clk_in) disable iff (rst_in)
        (refcp_reg[PD_B] && !latch_w) |=> ($stable(phase_reg) && $stable(fixed_reg) && $stable(fdbk_reg)))
        else $error("registers lost in power-down");
    a_serial_alive: assert property (@(posedge clk_in) disable iff (rst_in)
        (refcp_reg[PD_B] && sclk_in && !sclk_d_reg && !load_en_in)
        |=> (shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(sdata_in)}))
        else $error("serial input stalled in power-down");
    // Phase and modulator strobes; a stray pulse would upset the loop
    a_phase_step: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg0_w && phase_reg[PHADJ_B]) |=> (phase_step_out &&
        phase_acc_out == PH_W'($past(phase_acc_out) + $past(phase_reg[PH_HI:PH_LO]))))
        else $error("phase not advanced");
    a_phase_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !(reg0_w && phase_reg[PHADJ_B]) |=> $stable(phase_acc_out))
        else $error("phase moved without commit");
    a_step_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        !(reg0_w && phase_reg[PHADJ_B]) |=> !phase_step_out)
        else $error("phase step without commit");
    a_modulator_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        reg0_w |=> (modulator_reset_out == !$past(phase_reg[SDDIS_B])))
        else $error("modulator reset wrong");
    a_mod_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        !reg0_w |=> !modulator_reset_out)
        else $error("modulator reset without commit");
    // Field steering, checked two edges after the latch
    a_refcp_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP) |=> ##1 (charge_pump_current_out == $past(shift_reg[CP_HI:CP_LO], 2)))
        else $error("reference word not steered");
    a_mux_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP) |=> ##1 (test_output_select_out == $past(shift_reg[MUX_HI:MUX_LO], 2)))
        else $error("test output select not steered");
    a_doubler_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP) |=> ##1 (reference_doubler_enable_out == $past(shift_reg[DBL_B], 2)))
        else $error("doubler bit not steered");
    a_half_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP) |=> ##1 (reference_half_divide_out == $past(shift_reg[HALF_B], 2)))
        else $error("half divide bit not steered");
    a_ratio_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP && shift_reg[RDIV_HI:RDIV_LO] != 10'h000)
        |=> ##1 (ref_divide_ratio_out == $past(shift_reg[RDIV_HI:RDIV_LO], 2)))
        else $error("divider ratio not steered");
    a_polarity_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_REFCP) |=> ##1 (detector_polarity_out == $past(shift_reg[POL_B], 2)))
        else $error("polarity bit not steered");
    a_fb_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_FDBK) |=> ##1 (bleed_current_out == $past(shift_reg[BL_HI:BL_LO], 2)))
        else $error("feedback word not steered");
    a_source_steer: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_FDBK) |=> ##1 (feedback_source_select_out == $past(shift_reg[FBS_B], 2)))
        else $error("feedback source not steered");
    // Output divider: direct, buffered and committed paths
    a_odiv_direct: assert property (@(posedge clk_in) disable iff (rst_in)
        (latch_w && sel_w == SEL_FDBK && !refcp_reg[DBUF_B]) |=> (odiv_reg == $past(shift_reg[ODIV_HI:ODIV_LO])))
        else $error("unbuffered divider not applied");
    a_odiv_buffer: assert property (@(posedge clk_in) disable iff (rst_in)
        (refcp_reg[DBUF_B] && !reg0_w) |=> $stable(odiv_reg))
        else $error("buffered divider changed early");
    a_odiv_commit: assert property (@(posedge clk_in) disable iff (rst_in)
        reg0_w |=> (odiv_reg == $past(fdbk_reg[ODIV_HI:ODIV_LO])))
        else $error("divider not committed");
    a_divider_out: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(odiv_reg) |=> (output_divider_select_out == $past(odiv_reg)))
        else $error("divider output not updated");
    // Bleed gating against lock
    a_bleed_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        (fdbk_reg[GBL_B] && !lock_detect_in) |=> !bleed_enable_out)
        else $error("bleed on before lock");
    a_bleed_on: assert property (@(posedge clk_in) disable iff (rst_in)
        (fdbk_reg[NBL_B] && (!fdbk_reg[GBL_B] || lock_detect_in)) |=> bleed_enable_out)
        else $error("bleed not enabled");
    // Main scenarios
    c_commit_adjust: cover property (@(posedge clk_in) reg0_w && phase_reg[PHADJ_B]);
    c_power_down: cover property (@(posedge clk_in) refcp_reg[PD_B]);
    c_buffered_divider: cover property (@(posedge clk_in) refcp_reg[DBUF_B] && reg0_w);
    c_fixed_ok: cover property (@(posedge clk_in) fixed_word_ok_out);
    c_full_frame: cover property (@(posedge clk_in) latch_w && count_reg == CNT_FULL);
endmodule

// ===== src/scr_pkg.sv
package scr_pkg;
    // Serial word layout
    localparam int WORD_W      = 32;
    localparam int SEL_W       = 4;
    localparam int CNT_W       = 6;
    localparam logic [SEL_W-1:0] SEL_REG0  = 4'h0;
    localparam logic [SEL_W-1:0] SEL_PHASE = 4'h3;
    localparam logic [SEL_W-1:0] SEL_REFCP = 4'h4;
    localparam logic [SEL_W-1:0] SEL_FIXED = 4'h5;
    localparam logic [SEL_W-1:0] SEL_FDBK  = 4'h6;
    // Phase control word fields
    localparam int PH_LO   = 4;
    localparam int PH_HI   = 27;
    localparam int PH_W    = 24;
    localparam int PHADJ_B = 28;
    localparam int SDDIS_B = 30;
    // Reference / charge pump word fields
    localparam int MUX_LO  = 27;
    localparam int MUX_HI  = 29;
    localparam int DBL_B   = 26;
    localparam int HALF_B  = 25;
    localparam int RDIV_LO = 15;
    localparam int RDIV_HI = 24;
    localparam int DBUF_B  = 14;
    localparam int CP_LO   = 10;
    localparam int CP_HI   = 13;
    localparam int LVL_B   = 8;
    localparam int POL_B   = 7;
    localparam int PD_B    = 6;
    localparam int TRI_B   = 5;
    localparam int CRST_B  = 4;
    // Feedback / bleed word fields
    localparam int GBL_B   = 30;
    localparam int NBL_B   = 29;
    localparam int FBS_B   = 24;
    localparam int ODIV_LO = 21;
    localparam int ODIV_HI = 23;
    localparam int BL_LO   = 13;
    localparam int BL_HI   = 20;
    // Reset values, fixed word and full count
    localparam logic [WORD_W-1:0] ZERO_WORD  = 32'h0;
    localparam logic [WORD_W-1:0] FIXED_WORD = 32'h00800025;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 6'h0;
    localparam logic [CNT_W-1:0]  CNT_FULL   = 6'h20;
endpackage

// ===== bench/scr_host_model.sv
`timescale 1ns/1ns
// Host side of the three-wire port: shifts one word, MSB first, then pulses load enable
module scr_host_model
(
    // Clock and request
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [31:0] word_in,
    input  wire logic [31:0] half_in,
    // Serial port pins
    output logic             sclk_out,
    output logic             sdata_out,
    output logic             le_out,
    output logic             busy_out
);
    // One process owns every pin, so each has a single driver
    // Each level is held half_in clocks; half_in of 1 is the fastest legal pace
    initial
    begin
        sclk_out  = 1'b0;
        sdata_out = 1'b0;
        le_out    = 1'b0;
        busy_out  = 1'b0;
        forever
        begin
            @(posedge clk_in);
            if (start_in && !busy_out)
            begin
                busy_out = 1'b1;
                #1 sdata_out = word_in[31];
                for (int i = 31; i >= 0; i--)
                begin
                    repeat (half_in) @(posedge clk_in);
                    #1 sclk_out = 1'b1;
                    repeat (half_in) @(posedge clk_in);
                    #1 sclk_out = 1'b0;
                    // Next bit moves with the falling clock; after the last one show the inverse
                    sdata_out = (i > 0) ? word_in[i-1] : ~word_in[0];
                end
                repeat (half_in) @(posedge clk_in);
                #1 le_out = 1'b1;
                repeat (2) @(posedge clk_in);
                #1 le_out = 1'b0;
                @(posedge clk_in);
                #1 busy_out = 1'b0;
            end
        end
    end
endmodule

// ===== bench/synth_control_register_fields_tb.sv
`timescale 1ns/1ns
module synth_control_register_fields_tb;
    logic clk_in = 1'b0, rst_in = 1'b1, lock = 1'b0, start = 1'b0;
    logic [31:0] word = 32'h0;
    int half = 2, num_errors = 0, n_checks = 0, cyc = 0, n_step = 0, n_mr = 0;
    logic sclk, sdata, le, busy, step, mr, pol, tri_o, crst, od, ldr, bl_en, fbs, ok, dbl, hlf, lvl;
    logic [23:0] acc;
    logic [2:0] mux, odiv;
    logic [9:0] rdiv;
    logic [3:0] cp;
    logic [7:0] bl;
    always #5 clk_in = ~clk_in;
    scr_host_model i_scr_host_model (.clk_in(clk_in), .start_in(start), .word_in(word), .half_in(half),
        .sclk_out(sclk), .sdata_out(sdata), .le_out(le), .busy_out(busy));
    scr_regs i_scr_regs (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .sdata_in(sdata), .load_en_in(le),
        .lock_detect_in(lock), .phase_step_out(step), .phase_acc_out(acc), .modulator_reset_out(mr),
        .test_output_select_out(mux), .reference_doubler_enable_out(dbl), .reference_half_divide_out(hlf),
        .ref_divide_ratio_out(rdiv), .output_logic_level_out(lvl), .charge_pump_current_out(cp),
        .detector_polarity_out(pol), .charge_pump_tristate_out(tri_o), .counters_reset_out(crst),
        .outputs_disable_out(od), .lock_detect_reset_out(ldr), .bleed_enable_out(bl_en),
        .bleed_current_out(bl), .feedback_source_select_out(fbs), .output_divider_select_out(odiv),
        .fixed_word_ok_out(ok));
    // Pulse counters: one-cycle strobes are tallied every clock
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (!rst_in && step === 1'b1) n_step <= n_step + 1;
        if (!rst_in && mr === 1'b1) n_mr <= n_mr + 1;
        if (cyc == 30000)
        begin
            $display("Error at %0t: run did not finish in time", $time);
            num_errors = num_errors + 1;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One serial word, then time for the decoded outputs to settle
    task automatic wr(input logic [31:0] w);
        int t;
        t = 0;
        word = w;
        start = 1'b1;
        @(posedge clk_in);
        #1 start = 1'b0;
        @(posedge clk_in);
        while (busy && t < 2000)
        begin
            @(posedge clk_in);
            t++;
        end
        if (t >= 2000) chk(1, 0);
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic close_out();
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_in);
        #1 rst_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1 chk(rdiv, 1);
        // Phase adjust on, load reset off, resync bit left 0, autocal 0 in register 0
        wr(32'h51234563);
        wr(32'h00000000);
        wr(32'h00000000);
        chk(acc, 24'h2468ac);
        chk(n_step, 2);
        chk(n_mr, 0);
        wr(32'h00000003);
        wr(32'h00000000);
        chk(n_mr, 1);
        chk(n_step, 2);
        chk(acc, 24'h2468ac);
        half = 5;
        // Reserved top bits written 0
        wr(32'h2fffa584);
        chk({dbl, hlf, lvl, pol}, 4'hf);
        chk(mux, 3'h5);
        chk(rdiv, 10'h3ff);
        chk(cp, 4'h9);
        chk({tri_o, crst, od, ldr}, 4'h0);
        // Feedback word with reserved bits 0,1,010
        wr(32'h7554a006);
        chk({bl, fbs, odiv}, {8'ha5, 1'b1, 3'h2});
        chk(bl_en, 0);
        lock = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 chk(bl_en, 1);
        wr(32'h00800025);
        chk(ok, 1);
        wr(32'h00800035);
        chk(ok, 0);
        wr(32'h00800025);
        half = 2;
        // Power-down, also divider ratio of 1
        wr(32'h00009844);
        chk({tri_o, crst, od, ldr}, 4'hf);
        chk({rdiv, cp, pol}, {10'h1, 4'h6, 1'b0});
        chk({ok, bl, fbs}, {1'b1, 8'ha5, 1'b1});
        wr(32'h00004024);
        chk({tri_o, crst, od, ldr}, 4'h8);
        wr(32'h00004014);
        chk({tri_o, crst, od, ldr}, 4'h4);
        lock = 1'b0;
        // Divider select now buffered until register 0
        wr(32'h34a78006);
        chk({bl, fbs, bl_en}, {8'h3c, 1'b0, 1'b1});
        chk(odiv, 3'h2);
        // Test output select is 0 here, so no divider output is shown while committing
        wr(32'h00000000);
        chk(odiv, 3'h5);
        chk(n_mr, 2);
        // Unknown select must leave everything alone
        wr(32'h00000007);
        chk({odiv, cp, ok}, {3'h5, 4'h0, 1'b1});
        close_out();
    end
endmodule
